/* File: shared/wls_defs.vh */
`ifndef WLS_DEFS_VH
`define WLS_DEFS_VH

// ****************************************
// Register addresses (7-bit)
// ****************************************
`define WLS_ADDR_GPIO_WAKE 7'h47
`define WLS_ADDR_IN_LEVEL 7'h48
`define WLS_ADDR_HS_OVERLOAD 7'h54
`define WLS_ADDR_HS_OPEN_LOAD 7'h55
`define WLS_ADDR_PN_WAKE 7'h70

// ****************************************
// Reset values
// ****************************************
`define WLS_RST_BYTE 8'h00
`define WLS_RST_STATUS_BYTE 8'h00

// ****************************************
// Field positions
// ****************************************
`define WLS_BIT_SECOND_GPIO_WAKE 5
`define WLS_BIT_FIRST_GPIO_WAKE 4
`define WLS_BIT_DEV_MODE 7
`define WLS_BIT_PULLUP_CFG 6
`define WLS_BIT_SECOND_GPIO_LVL 5
`define WLS_BIT_FIRST_GPIO_LVL 4
`define WLS_BIT_SYNC 6
`define WLS_BIT_SILENCE 3
`define WLS_BIT_PN_ACTIVE 2
`define WLS_BIT_WUP 1
`define WLS_BIT_WUF 0

// ****************************************
// Serial frame layout
// ****************************************
`define WLS_FRAME_BITS 5'h10
`define WLS_ADDR_BITS 5'h07

// ****************************************
// Mode encodings
// ****************************************
`define WLS_SBC_NORMAL 2'h1
`define WLS_SBC_STOP 2'h2
`define WLS_GPIO_CFG_WAKE 3'h1
`define WLS_GPIO_CFG_LOW_SIDE 3'h2
`define WLS_GPIO_CFG_HIGH_SIDE 3'h3
`define WLS_CAN_MODE_NO_PN 3'h4

// ****************************************
// Counts and timing
// ****************************************
`define WLS_ECNT_OVERFLOW 6'h20
`define WLS_CLK_MHZ 25
`define WLS_SILENCE_US 1000

`endif

/* File: src/wls_spi_slave.v */
`timescale 1ns/10ps
`include "wls_defs.vh"
module wls_spi_slave (
    input wire clk,
    input wire resetn,
    input wire cs_n,
    input wire sclk,
    input wire sdi,
    input wire [7:0] rdata,
    output reg [6:0] addr_r,
    output reg [7:0] wdata_r,
    output reg wr_pulse_r,
    output reg rd_load_r,
    output reg sdo_r,
    output reg sdo_oe_r
);
    reg cs_d_r;
    reg sclk_d_r;
    reg rw_r;
    reg [4:0] bit_cnt_r;
    reg [15:0] shift_in_r;
    reg [7:0] shift_out_r;
    wire [7:0] status_byte = `WLS_RST_STATUS_BYTE;
    wire cs_fall = cs_d_r & ~cs_n;
    wire cs_rise = ~cs_d_r & cs_n;
    wire sclk_rise = ~sclk_d_r & sclk & ~cs_n;
    wire sclk_fall = sclk_d_r & ~sclk & ~cs_n;

    always @(posedge clk) begin
        if (!resetn) begin
            cs_d_r <= 1'b1;
            sclk_d_r <= 1'b0;
            rw_r <= 1'b0;
            bit_cnt_r <= 5'h00;
            shift_in_r <= 16'h0000;
            shift_out_r <= 8'h00;
            addr_r <= 7'h00;
            wdata_r <= 8'h00;
            wr_pulse_r <= 1'b0;
            rd_load_r <= 1'b0;
            sdo_r <= 1'b0;
            sdo_oe_r <= 1'b0;
        end else begin
            cs_d_r <= cs_n;
            sclk_d_r <= sclk;
            wr_pulse_r <= 1'b0;
            rd_load_r <= 1'b0;
            sdo_oe_r <= ~cs_n;
            if (cs_fall) begin
                bit_cnt_r <= 5'h00;
                sdo_r <= status_byte[0];
                shift_out_r <= {1'b0, status_byte[7:1]};
            end
            if (sclk_rise) begin
                shift_in_r <= {sdi, shift_in_r[15:1]};
                if (bit_cnt_r != 5'h1f)
                    bit_cnt_r <= bit_cnt_r + 5'h01;
                if (bit_cnt_r == `WLS_ADDR_BITS) begin
                    // Address is complete, fetch read data for the second byte
                    addr_r <= shift_in_r[15:9];
                    rw_r <= sdi;
                    rd_load_r <= 1'b1;
                end
            end
            if (rd_load_r)
                shift_out_r <= rdata;
            else if (sclk_fall) begin
                sdo_r <= shift_out_r[0];
                shift_out_r <= {1'b0, shift_out_r[7:1]};
            end
            // Only whole frames commit, short or long frames are dropped
            if (cs_rise && bit_cnt_r == `WLS_FRAME_BITS && rw_r) begin
                wdata_r <= shift_in_r[15:8];
                wr_pulse_r <= 1'b1;
            end
        end
    end
endmodule

/* File: src/wls_status_bank.v */
`timescale 1ns/10ps
`include "wls_defs.vh"
// Summary of operation
// RULE1 - GPIO wake register: bit5 second GPIO, bit4 first GPIO, sticky until cleared
// RULE2 - GPIO wake register bits 7:6 and 3:0 always read zero
// RULE3 - Level register bit7 shows development mode sensed on test pin
// RULE4 - Level register bit6 is one when interrupt pull-up was found
// RULE5 - Level bits 5 and 4 show GPIO levels, also in switch configurations
// RULE6 - Level bits 2..0 show wake input levels; bit3 reads zero
// RULE7 - GPIO levels refresh in Normal and Stop when wake, low- or high-side
// RULE8 - Cyclic wake inputs hold last sample, rewritten on each sampling
// RULE9 - GPIO pins never use cyclic sampling
// RULE10 - Overload register: sticky flag per switch in bits 3..0, upper zero
// RULE11 - Open-load register: sticky flag per switch in bits 3..0
// RULE12 - Sync bit set after error-free frame while selective wake runs
// RULE13 - Silence bit set when bus idle past timeout during selective wake
// RULE14 - Active bit only with no system error, config valid, mode bit2 set
// RULE15 - Selective wake starts on mode change unless new mode is 100
// RULE16 - Wake pattern bit set once pattern detected
// RULE17 - Wake frame bit set once valid wake frame detected
// RULE18 - System error on config error or counter overflow, only while enabled
// RULE19 - Writes to read-only or unused bits change nothing
module wls_status_bank #(
    parameter SILENCE_CYCLES = `WLS_SILENCE_US * `WLS_CLK_MHZ
) (
    input wire clk,
    input wire resetn,
    input wire spi_cs_n,
    input wire spi_sclk,
    input wire spi_sdi,
    output wire spi_sdo,
    output wire spi_sdo_oe,
    input wire [1:0] sbc_mode,
    input wire [2:0] first_gpio_cfg,
    input wire [2:0] second_gpio_cfg,
    input wire [1:0] gpio_pin,
    input wire [2:0] wake_pin,
    input wire [2:0] wake_cyclic,
    input wire [2:0] wake_sample_strobe,
    input wire fail_output_test_pin,
    input wire pullup_config_found,
    input wire [1:0] gpio_wake_event,
    input wire [3:0] hs_overload_event,
    input wire [3:0] hs_open_load_event,
    input wire [2:0] can_mode,
    input wire configuration_valid_bit,
    input wire pn_config_error,
    input wire pn_frame_ok,
    input wire pn_frame_error,
    input wire can_bus_activity,
    input wire can_wup_detected,
    input wire can_wuf_detected,
    input wire system_error_clear,
    output reg partial_network_system_error,
    output reg partial_network_active_flag,
    output reg [5:0] frame_error_count
);

    // ****************************************
    // Helpers
    // ****************************************
    // Hardware set wins over a clear in the same cycle
    function [3:0] sticky;
        input [3:0] cur;
        input [3:0] set;
        input [3:0] clr;
        begin
            sticky = set | (cur & ~clr);
        end
    endfunction

    function gpio_tracked;
        input [1:0] mode;
        input [2:0] cfg;
        begin
            gpio_tracked = (mode == `WLS_SBC_NORMAL || mode == `WLS_SBC_STOP) &&
                (cfg == `WLS_GPIO_CFG_WAKE || cfg == `WLS_GPIO_CFG_LOW_SIDE ||
                 cfg == `WLS_GPIO_CFG_HIGH_SIDE);
        end
    endfunction

    // ****************************************
    // Pin synchronisers
    // ****************************************
    wire [2:0] spi_q;
    wire [5:0] pin_q;

    wls_sync #(.W(3)) u_spi_sync (
        .clk(clk),
        .resetn(resetn),
        .d({spi_cs_n, spi_sclk, spi_sdi}),
        .q(spi_q)
    );

    wls_sync #(.W(6)) u_pin_sync (
        .clk(clk),
        .resetn(resetn),
        .d({fail_output_test_pin, gpio_pin, wake_pin}),
        .q(pin_q)
    );

    wire dev_mode_q = pin_q[5];
    wire [1:0] gpio_q = pin_q[4:3];
    wire [2:0] wake_q = pin_q[2:0];

    // ****************************************
    // Serial access
    // ****************************************
    wire [6:0] addr;
    wire [7:0] wdata;
    wire wr_pulse;
    reg [7:0] rdata;

    wls_spi_slave u_spi (
        .clk(clk),
        .resetn(resetn),
        .cs_n(spi_q[2]),
        .sclk(spi_q[1]),
        .sdi(spi_q[0]),
        .rdata(rdata),
        .addr_r(addr),
        .wdata_r(wdata),
        .wr_pulse_r(wr_pulse),
        .rd_load_r(),
        .sdo_r(spi_sdo),
        .sdo_oe_r(spi_sdo_oe)
    );

    // Clear-by-write: a zero written to a flag clears it, a one leaves it
    wire wr_gpio_wake = wr_pulse && addr == `WLS_ADDR_GPIO_WAKE;
    wire wr_overload = wr_pulse && addr == `WLS_ADDR_HS_OVERLOAD;
    wire wr_open_load = wr_pulse && addr == `WLS_ADDR_HS_OPEN_LOAD;

    // ****************************************
    // Wake source and switch flags
    // ****************************************
    reg [1:0] gpio_wake_r;
    reg [3:0] overload_r;
    reg [3:0] open_load_r;
    wire [3:0] gpio_wake_clr;
    wire [3:0] gpio_wake_nxt;

    assign gpio_wake_clr = wr_gpio_wake ? {2'b00, ~wdata[5:4]} : 4'h0;
    assign gpio_wake_nxt = sticky({2'b00, gpio_wake_r}, {2'b00, gpio_wake_event},
                                  gpio_wake_clr);

    always @(posedge clk) begin
        if (!resetn) begin
            gpio_wake_r <= 2'b00;
            overload_r <= 4'h0;
            open_load_r <= 4'h0;
        end else begin
            gpio_wake_r <= gpio_wake_nxt[1:0]; // RULE1
            overload_r <= sticky(overload_r, hs_overload_event,
                                 wr_overload ? ~wdata[3:0] : 4'h0); // RULE10
            open_load_r <= sticky(open_load_r, hs_open_load_event,
                                  wr_open_load ? ~wdata[3:0] : 4'h0); // RULE11
        end
    end

    // ****************************************
    // Input levels
    // ****************************************
    reg dev_mode_r;
    reg pullup_r;
    reg [1:0] gpio_lvl_r;
    reg [2:0] wake_lvl_r;
    integer i;

    always @(posedge clk) begin
        if (!resetn) begin
            dev_mode_r <= 1'b0;
            pullup_r <= 1'b0;
            gpio_lvl_r <= 2'b00;
            wake_lvl_r <= 3'h0;
        end else begin
            dev_mode_r <= dev_mode_q; // RULE3
            pullup_r <= pullup_config_found; // RULE4
            // Switch configurations still report the pin level
            if (gpio_tracked(sbc_mode, first_gpio_cfg))
                gpio_lvl_r[0] <= gpio_q[0]; // RULE5 RULE7 RULE9
            if (gpio_tracked(sbc_mode, second_gpio_cfg))
                gpio_lvl_r[1] <= gpio_q[1]; // RULE5 RULE7 RULE9
            for (i = 0; i < 3; i = i + 1) begin
                if (!wake_cyclic[i] || wake_sample_strobe[i])
                    wake_lvl_r[i] <= wake_q[i]; // RULE6 RULE8
            end
        end
    end

    // ****************************************
    // Selective wake status
    // ****************************************
    reg [2:0] can_mode_r;
    reg sync_r;
    reg silence_r;
    reg wup_r;
    reg wuf_r;
    reg [31:0] silence_cnt_r;
    wire pn_enabled = can_mode[2];
    wire mode_change = can_mode != can_mode_r;
    wire pn_allowed = !partial_network_system_error && configuration_valid_bit && pn_enabled;
    wire pn_start = mode_change && can_mode != `WLS_CAN_MODE_NO_PN && pn_allowed;
    wire ecnt_full = frame_error_count == `WLS_ECNT_OVERFLOW;
    wire partial_network_system_error_set = pn_enabled && (pn_config_error || ecnt_full);
    reg active_nxt;
    reg [5:0] ecnt_nxt;

    always @* begin
        active_nxt = partial_network_active_flag;
        if (!pn_allowed || partial_network_system_error_set)
            active_nxt = 1'b0; // RULE14
        else if (pn_start)
            active_nxt = 1'b1; // RULE15
    end

    always @* begin
        ecnt_nxt = frame_error_count;
        if (pn_start)
            ecnt_nxt = 6'h00;
        else if (pn_enabled && pn_frame_error && !ecnt_full)
            ecnt_nxt = frame_error_count + 6'h01;
        else if (pn_enabled && pn_frame_ok && frame_error_count != 6'h00 && !ecnt_full)
            ecnt_nxt = frame_error_count - 6'h01;
    end

    always @(posedge clk) begin
        if (!resetn) begin
            can_mode_r <= 3'h0;
            partial_network_system_error <= 1'b0;
            partial_network_active_flag <= 1'b0;
            frame_error_count <= 6'h00;
            sync_r <= 1'b0;
            silence_r <= 1'b0;
            wup_r <= 1'b0;
            wuf_r <= 1'b0;
            silence_cnt_r <= 32'h0000_0000;
        end else begin
            can_mode_r <= can_mode;
            // Sets only while selective wake is enabled; system_error_clear clears it in any mode
            if (partial_network_system_error_set)
                partial_network_system_error <= 1'b1; // RULE18
            else if (system_error_clear)
                partial_network_system_error <= 1'b0;
            partial_network_active_flag <= active_nxt;
            frame_error_count <= ecnt_nxt;
            if (!partial_network_active_flag)
                sync_r <= 1'b0;
            else if (pn_frame_ok)
                sync_r <= 1'b1; // RULE12
            if (!partial_network_active_flag || can_bus_activity) begin
                silence_cnt_r <= 32'h0000_0000;
                silence_r <= 1'b0;
            end else if (silence_cnt_r >= SILENCE_CYCLES - 1) begin
                silence_r <= 1'b1; // RULE13
            end else begin
                silence_cnt_r <= silence_cnt_r + 32'h0000_0001;
            end
            // A fresh activation forgets earlier detections
            if (can_wup_detected)
                wup_r <= 1'b1; // RULE16
            else if (pn_start)
                wup_r <= 1'b0;
            if (can_wuf_detected)
                wuf_r <= 1'b1; // RULE17
            else if (pn_start)
                wuf_r <= 1'b0;
        end
    end

    // ****************************************
    // Read decode
    // ****************************************
    // Write data is only used as a clear mask on the three flag registers
    always @* begin
        case (addr)
            `WLS_ADDR_GPIO_WAKE:
                rdata = {2'b00, gpio_wake_r, 4'h0}; // RULE2 RULE19
            `WLS_ADDR_IN_LEVEL:
                rdata = {dev_mode_r, pullup_r, gpio_lvl_r, 1'b0, wake_lvl_r}; // RULE6
            `WLS_ADDR_HS_OVERLOAD:
                rdata = {4'h0, overload_r}; // RULE10
            `WLS_ADDR_HS_OPEN_LOAD:
                rdata = {4'h0, open_load_r};
            `WLS_ADDR_PN_WAKE:
                rdata = {1'b0, sync_r, 2'b00, silence_r, partial_network_active_flag,
                         wup_r, wuf_r};
            default:
                rdata = `WLS_RST_BYTE;
        endcase
    end

endmodule

/* File: src/wls_sync.v */
`timescale 1ns/10ps
module wls_sync #(
    parameter W = 1
) (
    input wire clk,
    input wire resetn,
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
    reg [W-1:0] meta_r;

    always @(posedge clk) begin
        if (!resetn) begin
            meta_r <= {W{1'b0}};
            q <= {W{1'b0}};
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

/* File: test/tb.sv */
`timescale 1ns/10ps
module tb;
    logic clk = 1'h0;
    logic resetn = 1'h0;
    wire spi_cs_n, spi_sclk, spi_sdi, spi_sdo, spi_sdo_oe;
    logic [1:0] sbc_mode = 2'h1;
    logic [2:0] first_gpio_cfg = 3'h1;
    logic [2:0] second_gpio_cfg = 3'h3;
    logic [1:0] gpio_pin = 2'h2;
    logic [2:0] wake_pin = 3'h5;
    logic [2:0] wake_cyclic = 3'h0;
    logic [2:0] wake_sample_strobe = 3'h0;
    logic fail_output_test_pin = 1'h1;
    logic pullup_config_found = 1'h1;
    logic [1:0] gpio_wake_event = 2'h0;
    logic [3:0] hs_overload_event = 4'h0;
    logic [3:0] hs_open_load_event = 4'h0;
    logic [2:0] can_mode = 3'h0;
    logic configuration_valid_bit = 1'h1;
    logic pn_config_error = 1'h0;
    logic pn_frame_ok = 1'h0;
    logic pn_frame_error = 1'h0;
    logic can_bus_activity = 1'h0;
    logic can_wup_detected = 1'h0;
    logic can_wuf_detected = 1'h0;
    logic system_error_clear = 1'h0;
    wire partial_network_system_error, partial_network_active_flag;
    wire [5:0] frame_error_count;
    integer fails = 0;
    integer num_checks = 0;

    initial forever #20 clk = ~clk;

    // Short silence count keeps the run brief
    wls_status_bank #(.SILENCE_CYCLES(20)) u_dut (
        .clk, .resetn, .spi_cs_n, .spi_sclk, .spi_sdi, .spi_sdo, .spi_sdo_oe,
        .sbc_mode, .first_gpio_cfg, .second_gpio_cfg, .gpio_pin, .wake_pin,
        .wake_cyclic, .wake_sample_strobe, .fail_output_test_pin,
        .pullup_config_found, .gpio_wake_event, .hs_overload_event,
        .hs_open_load_event, .can_mode, .configuration_valid_bit, .pn_config_error,
        .pn_frame_ok, .pn_frame_error, .can_bus_activity, .can_wup_detected,
        .can_wuf_detected, .system_error_clear, .partial_network_system_error,
        .partial_network_active_flag, .frame_error_count
    );
    wls_host_model u_host (.clk, .spi_cs_n, .spi_sclk, .spi_sdi, .spi_sdo);

    // ****************************************
    // Access and compare helpers
    // ****************************************
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] q;
        u_host.xfer(a, 1'h0, 8'h00, q);
        chk($sformatf("reg %h", a), e, q);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] q;
        u_host.xfer(a, 1'h1, d, q);
    endtask
    task automatic complete_run;
        if (fails == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        complete_run();
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        repeat (6) @(negedge clk);
        resetn = 1'h1;
        repeat (6) @(negedge clk);
        chk("sdo_oe", 8'h00, {7'h00, spi_sdo_oe});
        fork
            rd(7'h47, 8'h00);
            begin
                repeat (50) @(negedge clk);
                chk("sdo_oe", 8'h01, {7'h00, spi_sdo_oe});
            end
        join
        rd(7'h54, 8'h00);
        rd(7'h55, 8'h00);
        rd(7'h70, 8'h00);
        rd(7'h48, 8'hE5);
        fail_output_test_pin = 1'h0;
        pullup_config_found = 1'h0;
        gpio_pin = 2'h1;
        wake_pin = 3'h2;
        second_gpio_cfg = 3'h2;
        rd(7'h48, 8'h12);
        sbc_mode = 2'h2;
        gpio_pin = 2'h2;
        rd(7'h48, 8'h22);
        sbc_mode = 2'h0;
        gpio_pin = 2'h1;
        rd(7'h48, 8'h22);
        wake_cyclic = 3'h1;
        wake_pin = 3'h3;
        rd(7'h48, 8'h22);
        @(negedge clk);
        wake_sample_strobe = 3'h1;
        @(negedge clk);
        wake_sample_strobe = 3'h0;
        rd(7'h48, 8'h23);
        gpio_wake_event = 2'h3;
        hs_overload_event = 4'hA;
        hs_open_load_event = 4'h5;
        @(negedge clk);
        gpio_wake_event = 2'h0;
        hs_overload_event = 4'h0;
        hs_open_load_event = 4'h0;
        rd(7'h47, 8'h30);
        wr(7'h47, 8'hDF);
        rd(7'h47, 8'h10);
        wr(7'h54, 8'hFF);
        rd(7'h54, 8'h0A);
        wr(7'h54, 8'h00);
        rd(7'h54, 8'h00);
        wr(7'h55, 8'h0E);
        rd(7'h55, 8'h04);
        wr(7'h48, 8'hFF);
        rd(7'h48, 8'h23);
        wr(7'h70, 8'hFF);
        rd(7'h70, 8'h00);
        rd(7'h10, 8'h00);
        can_mode = 3'h4;
        repeat (4) @(negedge clk);
        chk("active", 8'h00, {7'h00, partial_network_active_flag});
        can_mode = 3'h5;
        repeat (4) @(negedge clk);
        chk("active", 8'h01, {7'h00, partial_network_active_flag});
        pn_frame_ok = 1'h1;
        can_wup_detected = 1'h1;
        can_wuf_detected = 1'h1;
        @(negedge clk);
        pn_frame_ok = 1'h0;
        can_wup_detected = 1'h0;
        can_wuf_detected = 1'h0;
        rd(7'h70, 8'h4F);
        can_bus_activity = 1'h1;
        rd(7'h70, 8'h47);
        can_bus_activity = 1'h0;
        rd(7'h70, 8'h4F);
        pn_config_error = 1'h1;
        @(negedge clk);
        pn_config_error = 1'h0;
        repeat (4) @(negedge clk);
        chk("partial_network_system_error", 8'h01, {7'h00, partial_network_system_error});
        chk("active", 8'h00, {7'h00, partial_network_active_flag});
        system_error_clear = 1'h1;
        @(negedge clk);
        system_error_clear = 1'h0;
        can_mode = 3'h6;
        repeat (4) @(negedge clk);
        chk("partial_network_system_error", 8'h00, {7'h00, partial_network_system_error});
        chk("active", 8'h01, {7'h00, partial_network_active_flag});
        repeat (32) begin
            pn_frame_error = 1'h1;
            @(negedge clk);
            pn_frame_error = 1'h0;
            @(negedge clk);
        end
        repeat (3) @(negedge clk);
        chk("ecnt", 8'h20, {2'h0, frame_error_count});
        chk("partial_network_system_error", 8'h01, {7'h00, partial_network_system_error});
        complete_run();
    end
endmodule

/* File: test/wls_host_model.sv */
`timescale 1ns/10ps
// ****************************************
// Serial host: mode 0, LSB first, 16-bit frames
// ****************************************
module wls_host_model (
    input wire logic clk,
    output logic spi_cs_n,
    output logic spi_sclk,
    output logic spi_sdi,
    input wire logic spi_sdo
);
    initial begin
        spi_cs_n = 1'h1;
        spi_sclk = 1'h0;
        spi_sdi = 1'h0;
    end

    // Six clocks per half period: well above the synchroniser minimum
    task automatic xfer(input logic [6:0] a, input logic w, input logic [7:0] d,
                        output logic [7:0] q);
        logic [15:0] f;
        f = {d, w, a};
        q = 8'h00;
        @(negedge clk);
        spi_cs_n = 1'h0;
        repeat (6) @(negedge clk);
        for (int i = 0; i < 16; i++) begin
            spi_sdi = f[i];
            repeat (6) @(negedge clk);
            if (i > 7) q[i-8] = spi_sdo;
            spi_sclk = 1'h1;
            repeat (6) @(negedge clk);
            spi_sclk = 1'h0;
        end
        repeat (6) @(negedge clk);
        spi_cs_n = 1'h1;
        // Released line must not look like the last bit
        spi_sdi = ~spi_sdi;
        repeat (8) @(negedge clk);
    endtask
endmodule

/* File: test/wls_status_bank_props.sv */
`timescale 1ns/10ps
// ****************************************
// Selective-wake activation and system-error checks
// ****************************************
module wls_status_bank_props (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [2:0] can_mode,
    input wire logic configuration_valid_bit,
    input wire logic pn_config_error,
    input wire logic system_error_clear,
    input wire logic partial_network_system_error,
    input wire logic partial_network_active_flag,
    input wire logic [5:0] frame_error_count
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // Mode change that qualifies for activation
    sequence s_enter_pn;
        $changed(can_mode) && can_mode[2] && (can_mode != 3'h4)
            && configuration_valid_bit && !partial_network_system_error
            && !pn_config_error && (frame_error_count != 6'h20);
    endsequence
    // Change to the one code with bit2 set (100) that must never activate
    sequence s_enter_no_pn;
        $changed(can_mode) && (can_mode == 3'h4) && !partial_network_active_flag;
    endsequence

    AST_PN_STARTS: assert property (s_enter_pn |-> ##[0:2] partial_network_active_flag)
        else $error("selective wake not started on mode change");
    AST_NO_PN_CODE: assert property (s_enter_no_pn |=> !partial_network_active_flag [*3])
        else $error("selective wake started by excluded mode code");
    AST_ACTIVE_NEEDS_EN: assert property (!can_mode[2] [*2] |-> !partial_network_active_flag)
        else $error("selective wake active without enable bit");
    AST_ACTIVE_NO_ERR: assert property (
        partial_network_system_error [*2] |-> !partial_network_active_flag)
        else $error("selective wake active with system error");
    AST_ERR_ONLY_EN: assert property (
        $rose(partial_network_system_error) |-> $past(can_mode[2]))
        else $error("system error updated while selective wake disabled");
    AST_CFG_ERR_SETS: assert property (
        pn_config_error && can_mode[2] |-> ##[1:2] partial_network_system_error)
        else $error("configuration error did not raise system error");
    AST_OVERFLOW_SETS: assert property ((frame_error_count == 6'h20) && can_mode[2]
        |-> ##[0:1] partial_network_system_error)
        else $error("counter overflow did not raise system error");
    AST_ERR_HOLDS: assert property (partial_network_system_error && !system_error_clear
        |=> partial_network_system_error)
        else $error("system error dropped without clear");
endmodule

bind wls_status_bank wls_status_bank_props u_props (
    .clk, .resetn, .can_mode, .configuration_valid_bit, .pn_config_error,
    .system_error_clear, .partial_network_system_error,
    .partial_network_active_flag, .frame_error_count
);
